// file: inc/fmo_pkg.sv
/*
 * fmo_pkg: constants of the frame memory organisation block.
 * assumes a 24-bit pointer space and two 12-bit data lanes.
 */
package fmo_pkg;
  localparam int unsigned LANE_W = 12;
  localparam int unsigned PTR_W  = 24;
  localparam int unsigned AV_AW  = 4;
  // ************************************************************
  // register offsets and reset values
  // ************************************************************
  localparam logic [3:0]  REG_CTRL = 4'h0;
  localparam logic [3:0]  REG_STAT = 4'h4;
  localparam logic [3:0]  REG_LVL0 = 4'h8;
  localparam logic [3:0]  REG_LVL1 = 4'hC;
  localparam int unsigned CTRL_DIR_BIT = 4;
  localparam int unsigned STAT_W1_LSB  = 4;
  localparam int unsigned STAT_DUAL_BIT = 8;
  localparam logic [3:0]  MODE_RST = 4'h0;
  localparam logic        DIR_RST  = 1'b0;
  localparam int unsigned RST_SYNC_STAGES = 2;
  // ************************************************************
  // word counts per organisation
  // ************************************************************
  localparam logic [23:0] DEP_8  = 24'h766EC0;
  localparam logic [23:0] DEP_10 = 24'h5EBF00;
  localparam logic [23:0] DEP_12 = 24'h4EF480;
  localparam logic [23:0] DEP_16 = 24'h3B3760;
  localparam logic [23:0] DEP_20 = 24'h2F5F80;
  localparam logic [23:0] DEP_24 = 24'h277A40;
  localparam logic [3:0]  LW_8  = 4'h8;
  localparam logic [3:0]  LW_10 = 4'hA;
  localparam logic [3:0]  LW_12 = 4'hC;
  localparam logic [3:0]  LW_0  = 4'h0;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } fmo_bus_e;
endpackage

// file: logic/fmo_skid.sv
/*
 * fmo_skid: two-entry buffer with valid and ready on both sides.
 * assumes one clock; clear drops both entries.
 */
`timescale 1ns/10ps
module fmo_skid #(
  parameter int unsigned W = 12
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         clr_i,
  // filling side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // draining side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  logic [W-1:0] e0_reg, e0_next, e1_reg, e1_next;
  logic [1:0]   cnt_reg, cnt_next;
  logic         vld_reg, vld_next, rdy_reg, rdy_next;
  logic         push, pop;

  always_comb begin
    push = in_valid_i && rdy_reg;
    pop = vld_reg && out_ready_i;
    e0_next = e0_reg;
    e1_next = e1_reg;
    cnt_next = cnt_reg;
    unique case ({push, pop})
      2'b10: begin
        if (cnt_reg == 2'h0) e0_next = in_data_i;
        else e1_next = in_data_i;
        cnt_next = cnt_reg + 2'h1;
      end
      2'b01: begin
        e0_next = e1_reg;
        cnt_next = cnt_reg - 2'h1;
      end
      2'b11: begin
        // with one entry the new word replaces the leaving one
        e0_next = (cnt_reg == 2'h1) ? in_data_i : e1_reg;
        if (cnt_reg == 2'h2) e1_next = in_data_i;
      end
      default: ;
    endcase
    if (clr_i) cnt_next = 2'h0;
    vld_next = cnt_next != 2'h0;
    rdy_next = cnt_next != 2'h2;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      e0_reg <= '0;
      e1_reg <= '0;
      cnt_reg <= 2'h0;
      vld_reg <= 1'b0;
      rdy_reg <= 1'b1;
    end else begin
      e0_reg <= e0_next;
      e1_reg <= e1_next;
      cnt_reg <= cnt_next;
      vld_reg <= vld_next;
      rdy_reg <= rdy_next;
    end
  end

  assign in_ready_o = rdy_reg;
  assign out_valid_o = vld_reg;
  assign out_data_o = e0_reg;
endmodule

// file: logic/fmo_lane.sv
/*
 * fmo_lane: one 12-bit memory lane with write and read pointers.
 * assumes push only with room and pop only with data present.
 */
`timescale 1ns/10ps
module fmo_lane #(
  parameter int unsigned MEM_AW = 10
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clr_i,
  // organisation
  input  wire logic [23:0] depth_i,
  // data
  input  wire logic        push_i,
  input  wire logic [11:0] wdata_i,
  input  wire logic        pop_i,
  output logic [11:0]      rdata_o,
  output logic             rvalid_o,
  // pointer loads
  input  wire logic        wp_load_i,
  input  wire logic        rp_load_i,
  input  wire logic [23:0] ptr_i,
  // state
  output logic             space_o,
  output logic             avail_o,
  output logic [23:0]      level_o,
  output logic [23:0]      wp_o,
  output logic [23:0]      rp_o
);
  // physical store is smaller than the pointer span: addresses alias
  logic [11:0] mem [2**MEM_AW];
  logic [23:0] wp_reg, wp_next, rp_reg, rp_next, lvl_reg, lvl_next;
  logic [11:0] rd_reg, rd_next;
  logic        rv_reg, rv_next, sp_reg, sp_next, av_reg, av_next;

  function automatic logic [23:0] step(input logic [23:0] p, input logic [23:0] d);
    step = (p == d - 24'h1) ? 24'h0 : p + 24'h1;
  endfunction

  always_comb begin
    wp_next = wp_reg;
    rp_next = rp_reg;
    rd_next = rd_reg;
    rv_next = pop_i;
    lvl_next = lvl_reg + {23'h0, push_i} - {23'h0, pop_i};
    if (pop_i) rd_next = mem[rp_reg[MEM_AW-1:0]];
    if (push_i) wp_next = step(wp_reg, depth_i);
    if (pop_i) rp_next = step(rp_reg, depth_i);
    // an external load wins over the pointer's own step
    if (wp_load_i) wp_next = ptr_i;
    if (rp_load_i) rp_next = ptr_i;
    if (wp_load_i || rp_load_i) begin
      lvl_next = (wp_next >= rp_next) ? wp_next - rp_next
                                      : wp_next + depth_i - rp_next;
    end
    if (clr_i) begin
      wp_next = 24'h0;
      rp_next = 24'h0;
      lvl_next = 24'h0;
      rv_next = 1'b0;
    end
    sp_next = lvl_next != depth_i;
    av_next = lvl_next != 24'h0;
  end

  always_ff @(posedge clk_i) begin
    if (push_i) mem[wp_reg[MEM_AW-1:0]] <= wdata_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_reg <= 24'h0;
      rp_reg <= 24'h0;
      lvl_reg <= 24'h0;
      rd_reg <= 12'h000;
      rv_reg <= 1'b0;
      sp_reg <= 1'b1;
      av_reg <= 1'b0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      lvl_reg <= lvl_next;
      rd_reg <= rd_next;
      rv_reg <= rv_next;
      sp_reg <= sp_next;
      av_reg <= av_next;
    end
  end

  assign rdata_o = rd_reg;
  assign rvalid_o = rv_reg;
  assign space_o = sp_reg;
  assign avail_o = av_reg;
  assign level_o = lvl_reg;
  assign wp_o = wp_reg;
  assign rp_o = rp_reg;
endmodule

// file: logic/fmo_top.sv
/*
 * fmo_top: frame memory organisation, pointer override, register port.
 * assumes one 200 MHz clock, stream ports synchronous to it, and an
 * Avalon-MM master that holds each request until waitrequest is low.
 */
// Operation
// - mode 000x gives one channel of 8-bit words, 7,761,600 deep.
// - mode 0010 gives one channel of 10-bit words, 6,209,280 deep.
// - mode 0011 gives one channel of 12-bit words, 5,174,400 deep.
// - mode 100x gives one channel of 16-bit words, 3,880,800 deep.
// - mode 1010 gives one channel of 20-bit words, 3,104,640 deep.
// - mode 1011 gives one channel of 24-bit words, 2,587,200 deep.
// - mode 110x gives two independent 8-bit channels, 3,880,800 deep each.
// - mode 1110 gives two independent 10-bit channels, 3,104,640 deep each.
// - mode 1111 gives two independent 12-bit channels, 2,587,200 deep each.
// - direction 0 and write set low load write pointer from external port.
// - direction 1 and read set low load read pointer from external port.
// - pointer override works in single-channel modes only, never in dual.
`timescale 1ns/10ps
module fmo_top #(
  parameter int unsigned MEM_AW    = 10,
  parameter int unsigned DEPTH_DIV = 1
) (
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_n_i,
  // register port
  input  wire logic [fmo_pkg::AV_AW-1:0] avs_address_i,
  input  wire logic                      avs_read_i,
  input  wire logic                      avs_write_i,
  input  wire logic [31:0]               avs_writedata_i,
  input  wire logic [3:0]                avs_byteenable_i,
  output logic [31:0]                    avs_readdata_o,
  output logic                           avs_waitrequest_o,
  // write stream
  input  wire logic [1:0]                wr_valid_i,
  output logic [1:0]                     wr_ready_o,
  input  wire logic [11:0]               lane0_data_i,
  input  wire logic [11:0]               lane1_data_i,
  // read stream
  output logic [1:0]                     rd_valid_o,
  input  wire logic [1:0]                rd_ready_i,
  output logic [11:0]                    lane0_data_o,
  output logic [11:0]                    lane1_data_o,
  // pointer override
  input  wire logic [23:0]               ext_ptr_i,
  input  wire logic                      write_pointer_set_n_i,
  input  wire logic                      read_pointer_set_n_i
);
  import fmo_pkg::*;

  // ************************************************************
  // reset release
  // ************************************************************
  logic [RST_SYNC_STAGES-1:0] rst_sh_reg;
  logic                       rst_sync_n;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sh_reg <= '0;
    end else begin
      rst_sh_reg <= {rst_sh_reg[RST_SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sh_reg[RST_SYNC_STAGES-1];

  // ************************************************************
  // register port
  // ************************************************************
  fmo_bus_e    bus_reg, bus_next;
  logic [31:0] rdat_reg, rdat_next, rmux;
  logic [3:0]  mode_reg, mode_next;
  logic        dir_reg, dir_next;
  logic        ctrl_wr;
  logic [23:0] level [2];

  logic        dual;
  logic [3:0]  w0, w1;
  logic [23:0] dep_raw, depth;

  always_comb begin
    unique case (avs_address_i)
      REG_CTRL: rmux = {27'h0, dir_reg, mode_reg};
      REG_STAT: rmux = {23'h0, dual, w1, w0};
      REG_LVL0: rmux = {8'h00, level[0]};
      REG_LVL1: rmux = {8'h00, level[1]};
      default:  rmux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    bus_next = BUS_IDLE;
    rdat_next = rdat_reg;
    mode_next = mode_reg;
    dir_next = dir_reg;
    // one wait cycle, then the answer; writes act on the answering edge
    ctrl_wr = (bus_reg == BUS_ACK) && avs_write_i
              && (avs_address_i == REG_CTRL) && avs_byteenable_i[0];
    if ((bus_reg == BUS_IDLE) && (avs_read_i || avs_write_i)) begin
      bus_next = BUS_ACK;
      rdat_next = avs_read_i ? rmux : 32'h0000_0000;
    end
    if (ctrl_wr) begin
      mode_next = avs_writedata_i[3:0];
      dir_next = avs_writedata_i[CTRL_DIR_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_reg <= BUS_IDLE;
      rdat_reg <= 32'h0000_0000;
      mode_reg <= MODE_RST;
      dir_reg <= DIR_RST;
    end else begin
      bus_reg <= bus_next;
      rdat_reg <= rdat_next;
      mode_reg <= mode_next;
      dir_reg <= dir_next;
    end
  end

  assign avs_waitrequest_o = bus_reg[0];
  assign avs_readdata_o = rdat_reg;

  // ************************************************************
  // organisation decode
  // ************************************************************
  always_comb begin
    dual = 1'b0;
    w0 = LW_8;
    w1 = LW_0;
    dep_raw = DEP_8;
    unique casez (mode_reg)
      4'b000?: ;
      4'b0010: begin w0 = LW_10; dep_raw = DEP_10; end
      4'b0011: begin w0 = LW_12; dep_raw = DEP_12; end
      4'b100?: begin w1 = LW_8; dep_raw = DEP_16; end
      4'b1010: begin w0 = LW_10; w1 = LW_10; dep_raw = DEP_20; end
      4'b1011: begin w0 = LW_12; w1 = LW_12; dep_raw = DEP_24; end
      4'b110?: begin dual = 1'b1; w1 = LW_8; dep_raw = DEP_16; end
      4'b1110: begin
        dual = 1'b1; w0 = LW_10; w1 = LW_10; dep_raw = DEP_20;
      end
      4'b1111: begin
        dual = 1'b1; w0 = LW_12; w1 = LW_12; dep_raw = DEP_24;
      end
      // 01xx is undefined: falls back to the 8-bit organisation
      default: ;
    endcase
    depth = 24'(dep_raw / DEPTH_DIV);
  end

  // ************************************************************
  // lanes and output buffers
  // ************************************************************
  logic [11:0] msk [2];
  logic [11:0] din [2];
  logic [11:0] rdat [2];
  logic [11:0] dout [2];
  logic [23:0] wp [2];
  logic [23:0] rp [2];
  logic [1:0]  push, issue, rv, space, avail, sk_rdy, sk_ordy;
  logic        wp_ld, rp_ld;

  assign wp_ld = !dual && !dir_reg && !write_pointer_set_n_i;
  assign rp_ld = !dual && dir_reg && !read_pointer_set_n_i;
  assign din[0] = lane0_data_i;
  assign din[1] = lane1_data_i;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    // upper bits kept, low bits dropped
    assign msk[c] = 12'hFFF << (4'hC - ((c == 0) ? w0 : w1));
    // single mode runs lane 1 in lockstep with lane 0
    assign push[c] = wr_valid_i[dual ? c : 0] && space[c];
    assign issue[c] = dual || (c == 0) ? avail[c] && !rv[c] && sk_rdy[c]
                                       : issue[0];
    assign sk_ordy[c] = rd_ready_i[dual ? c : 0];

    fmo_lane #(
      .MEM_AW (MEM_AW)
    ) u_lane (
      .clk_i     (core_clk_i),
      .rst_n_i   (rst_sync_n),
      .clr_i     (ctrl_wr),
      .depth_i   (depth),
      .push_i    (push[c]),
      .wdata_i   (din[c] & msk[c]),
      .pop_i     (issue[c]),
      .rdata_o   (rdat[c]),
      .rvalid_o  (rv[c]),
      // loads gated off in dual modes
      .wp_load_i (wp_ld),
      .rp_load_i (rp_ld),
      .ptr_i     (ext_ptr_i),
      .space_o   (space[c]),
      .avail_o   (avail[c]),
      .level_o   (level[c]),
      .wp_o      (wp[c]),
      .rp_o      (rp[c])
    );

    fmo_skid #(
      .W (LANE_W)
    ) u_skid (
      .clk_i       (core_clk_i),
      .rst_n_i     (rst_sync_n),
      .clr_i       (ctrl_wr),
      .in_valid_i  (rv[c]),
      .in_ready_o  (sk_rdy[c]),
      .in_data_i   (rdat[c]),
      .out_valid_o (rd_valid_o[c]),
      .out_ready_i (sk_ordy[c]),
      .out_data_o  (dout[c])
    );
  end

  assign wr_ready_o = space;
  assign lane0_data_o = dout[0];
  assign lane1_data_o = dout[1];

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_sync_n);

  a_mode_sgl_8: assert property (mode_reg ==? 4'b000? |->
    !dual && w0 == LW_8 && w1 == LW_0 && dep_raw == DEP_8) else $error("mode 000x wrong");
  a_mode_sgl_10: assert property (mode_reg == 4'h2 |->
    !dual && w0 == LW_10 && w1 == LW_0 && dep_raw == DEP_10) else $error("mode 2 wrong");
  a_mode_sgl_12: assert property (mode_reg == 4'h3 |->
    !dual && w0 == LW_12 && w1 == LW_0 && dep_raw == DEP_12) else $error("mode 3 wrong");
  a_mode_sgl_16: assert property (mode_reg ==? 4'b100? |->
    !dual && w0 == LW_8 && w1 == LW_8 && dep_raw == DEP_16) else $error("mode 100x wrong");
  a_mode_sgl_20: assert property (mode_reg == 4'hA |->
    !dual && w1 == LW_10 && dep_raw == DEP_20) else $error("mode A wrong");
  a_mode_sgl_24: assert property (mode_reg == 4'hB |->
    !dual && w1 == LW_12 && dep_raw == DEP_24) else $error("mode B wrong");
  a_mode_dual_8: assert property (mode_reg ==? 4'b110? |->
    dual && w1 == LW_8 && dep_raw == DEP_16) else $error("mode 110x wrong");
  a_mode_dual_10: assert property (mode_reg == 4'hE |->
    dual && w0 == LW_10 && dep_raw == DEP_20) else $error("mode E wrong");
  a_mode_dual_12: assert property (mode_reg == 4'hF |->
    dual && w0 == LW_12 && dep_raw == DEP_24) else $error("mode F wrong");
  a_wp_override: assert property (!dual && !dir_reg && !write_pointer_set_n_i
    && !ctrl_wr |=> wp[0] == $past(ext_ptr_i) && wp[1] == $past(ext_ptr_i))
    else $error("write pointer not loaded");
  a_rp_override: assert property (!dual && dir_reg && !read_pointer_set_n_i
    && !ctrl_wr |=> rp[0] == $past(ext_ptr_i) && rp[1] == $past(ext_ptr_i))
    else $error("read pointer not loaded");
  a_dual_no_ovr: assert property (dual && !push[0] && !issue[0] && !ctrl_wr
    |=> $stable(wp[0]) && $stable(rp[0])) else $error("dual pointer moved");
  a_lane_pack: assert property (rd_valid_o[1] && !dual
    |-> (lane1_data_o & ~msk[1]) == 12'h000) else $error("lane low bits used");

  c_dual_read: cover property (dual && rd_valid_o[1] && rd_ready_i[1]);
  c_ovr_load: cover property (wp_ld ##1 push[0]);
  c_buf_stall: cover property (rd_valid_o[0] && !sk_rdy[0]);
  c_wide_write: cover property (w1 == LW_12 && push[1]);
endmodule

// file: verif/fmo_sink.sv
/*
 * fmo_sink: read-side partner, the video logic that takes words.
 * assumes it sees only the read ready it drives; the bench checks data.
 */
`timescale 1ns/10ps
module fmo_sink (
  // clock and control
  input  wire logic clk_i,
  input  wire logic en_i,
  // read side
  output logic [1:0] ready_o
);
  // ********************
  // ready pattern
  // ********************
  initial ready_o = 2'h0;
  // random stalls so the output buffer fills and must hold its words
  always @(posedge clk_i) begin
    ready_o <= en_i ? 2'($urandom) : 2'h0;
  end
endmodule

// file: verif/test_frame_memory_mode_and_pointer_override.sv
/*
 * test_frame_memory_mode_and_pointer_override: self-checking bench for fmo_top.
 * assumes fmo_pkg and the fmo_sink partner; depths are shortened by DIV.
 */
`timescale 1ns/10ps
module test_frame_memory_mode_and_pointer_override;
  import fmo_pkg::*;
  localparam int unsigned DIV = 16384;
  // ********************
  // signals and model state
  // ********************
  logic        clk = 1'b0, rst_n = 1'b0, av_rd = 1'b0, av_wr = 1'b0, av_wait;
  logic [3:0]  av_a = 4'h0, av_be = 4'hF;
  logic [31:0] av_wd = 32'h0, av_q, lv;
  logic [1:0]  wr_v = 2'h0, wr_r, rd_v, rd_r;
  logic [11:0] d0 = 12'h0, d1 = 12'h0, q0, q1, m0 = 12'h0, m1 = 12'h0;
  logic [23:0] ext = 24'h0;
  logic        wset_n = 1'b1, read_pointer_set_n_n = 1'b1, sink_en = 1'b0, dual = 1'b0;
  int          lw0, lw1, n_fail = 0, compares = 0, cyc = 0;
  int unsigned dep;
  logic [23:0] exq0[$], exq1[$];

  fmo_top #(.MEM_AW(10), .DEPTH_DIV(DIV)) i_fmo_top (
    .core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(av_a), .avs_read_i(av_rd),
    .avs_write_i(av_wr), .avs_writedata_i(av_wd), .avs_byteenable_i(av_be),
    .avs_readdata_o(av_q), .avs_waitrequest_o(av_wait), .wr_valid_i(wr_v),
    .wr_ready_o(wr_r), .lane0_data_i(d0), .lane1_data_i(d1), .rd_valid_o(rd_v),
    .rd_ready_i(rd_r), .lane0_data_o(q0), .lane1_data_o(q1), .ext_ptr_i(ext),
    .write_pointer_set_n_i(wset_n), .read_pointer_set_n_i(read_pointer_set_n_n)
  );
  fmo_sink i_fmo_sink (.clk_i(clk), .en_i(sink_en), .ready_o(rd_r));

  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // ********************
  // compares and bus cycles
  // ********************
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [23:0] g, input logic [23:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    av_a <= a;
    av_wr <= w;
    av_rd <= !w;
    av_wd <= d;
    do @(posedge clk); while (av_wait !== 1'b0);
    q = av_q;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk_reg(q, e);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // ********************
  // organisation model
  // ********************
  function automatic int unsigned base(input int w);
    case (w)
      8:       return 7761600;
      10:      return 6209280;
      12:      return 5174400;
      16:      return 3880800;
      20:      return 3104640;
      default: return 2587200;
    endcase
  endfunction
  task automatic cfg(input logic [4:0] c);
    int w;
    dual = c[3] & c[2];
    w = (c[1] && !(c[2] && !c[3])) ? (c[0] ? 12 : 10) : 8;
    if (c[3] && !c[2]) w = w * 2;
    lw0 = w > 12 ? w / 2 : w;
    lw1 = dual ? w : (w > 12 ? w / 2 : 0);
    m0 = ~(12'hFFF >> lw0);
    m1 = ~(12'hFFF >> lw1);
    // a dual channel is as deep as a single one of twice the width
    dep = base(dual ? 2 * w : w) / DIV;
    exq0.delete();
    exq1.delete();
    wr(REG_CTRL, {27'h0, c});
    rd(REG_CTRL, {27'h0, c});
    rd(REG_STAT, {23'h0, dual, 4'(lw1), 4'(lw0)});
  endtask
  task automatic fill(input int lim);
    int idle, n;
    logic [1:0] tk;
    idle = 0;
    n = 0;
    @(posedge clk);
    wr_v <= dual ? 2'h3 : 2'h1;
    d0 <= 12'($urandom);
    d1 <= 12'($urandom);
    while (idle < 6 && n < lim) begin
      @(posedge clk);
      tk = wr_v & wr_r & {dual, 1'b1};
      if (tk[0]) begin
        exq0.push_back(dual ? {12'h0, d0 & m0} : {d1 & m1, d0 & m0});
        d0 <= 12'($urandom);
        if (!dual) d1 <= 12'($urandom);
        n++;
      end
      if (tk[1]) begin
        exq1.push_back({12'h0, d1 & m1});
        d1 <= 12'($urandom);
      end
      idle = (tk != 2'h0) ? 0 : idle + 1;
    end
    wr_v <= 2'h0;
    repeat (8) @(posedge clk);
  endtask
  task automatic drain();
    sink_en <= 1'b1;
    while (exq0.size() + exq1.size() > 0) @(posedge clk);
    sink_en <= 1'b0;
    repeat (8) @(posedge clk);
    chk_reg({30'h0, rd_v}, 32'h0);
    rd(REG_LVL0, 32'h0);
  endtask
  task automatic ovr(input logic w, input logic [23:0] p);
    @(posedge clk);
    ext <= p;
    if (w) wset_n <= 1'b0;
    else read_pointer_set_n_n <= 1'b0;
    @(posedge clk);
    wset_n <= 1'b1;
    read_pointer_set_n_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // an empty queue yields unknown, so a stray word always mismatches
  always @(posedge clk) begin
    if (rd_v[0] && rd_r[0])
      chk_word({(lw1 != 0 && !dual) ? q1 : 12'h0, q0},
               exq0.size() ? exq0.pop_front() : 24'hx);
    if (dual && rd_v[1] && rd_r[1])
      chk_word({12'h0, q1}, exq1.size() ? exq1.pop_front() : 24'hx);
  end
  task automatic tally_and_finish();
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ********************
  // main sequence
  // ********************
  initial begin
    void'($urandom(32'hEC34));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(REG_CTRL, 32'h0);
    rd(REG_STAT, 32'h8);
    rd(4'h2, 32'h0);
    av_be <= 4'hE;
    wr(REG_CTRL, 32'hB);
    av_be <= 4'hF;
    rd(REG_CTRL, 32'h0);
    for (int c = 0; c < 16; c++) begin
      cfg(5'(c));
      fill(1000);
      rd(REG_LVL0, dep);
      if (dual) rd(REG_LVL1, dep);
      drain();
    end
    cfg(5'h00);
    fill(5);
    bus(1'b0, REG_LVL0, 32'h0, lv);
    ovr(1'b0, 24'd9);
    rd(REG_LVL0, lv);
    ovr(1'b1, 24'd20);
    rd(REG_LVL0, lv + 32'd15);
    cfg(5'h10);
    fill(5);
    bus(1'b0, REG_LVL0, 32'h0, lv);
    ovr(1'b1, 24'd30);
    rd(REG_LVL0, lv);
    ovr(1'b0, 24'd1);
    rd(REG_LVL0, 32'd4);
    cfg(5'h0C);
    fill(5);
    bus(1'b0, REG_LVL0, 32'h0, lv);
    ovr(1'b1, 24'd20);
    ovr(1'b0, 24'd3);
    rd(REG_LVL0, lv);
    tally_and_finish();
  end
endmodule
